// *** rtl/clock_domain_gating_map.svh ***
// Register offsets, field positions and reset values of the clock block.
`ifndef CLOCK_DOMAIN_GATING_MAP_SVH
`define CLOCK_DOMAIN_GATING_MAP_SVH
// ==========================================================
// Byte addresses of the registers.
`define OFS_STDIV 32'hFFFFE108
`define OFS_A3CON 32'hFFFFE140
`define OFS_DDIS 32'hFFFFE150
`define OFS_MSRC 32'hFFFFE154
`define OFS_ASRC 32'hFFFFE158
`define OFS_RSRC 32'hFFFFE15C
`define OFS_PDIV 32'hFFFFE160
`define OFS_GSTAT 32'hFFFFE164
`define OFS_PLLA 32'hFFFFE170
`define OFS_PLLB 32'hFFFFE174
`define OFS_PLLC 32'hFFFFE178
// ==========================================================
// Reset values.
`define RST_A3CON 32'h09090001
`define RST_ASRC 32'h00000909
`define RST_RSRC 32'h00000009
`define RST_ZERO 32'h00000000
// ==========================================================
// Field positions and codes.
`define SRC_PERIPH 4'h9
`define SRC_LIMP 3'h5
`define ST_ACT_BIT 8
`define A3_DIVDIS_BIT 4
`define SLIPRST_BIT 0
`define FMOD_BIT 31
`define GS_FAIL 0
`define GS_SLIP1 8
`define GS_SLIP2 9
`define GS_VALID 16
// ==========================================================
// Oscillator monitor: window of 16 reference edges, bounds exclusive.
`define MON_LAST 4'hF
`define OSC_LO 7'h04
`define OSC_HI 7'h40
`endif

// *** rtl/clk_pkg.sv ***
// Types shared by the clock block.
package clk_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0] src_code_t;
endpackage

// *** rtl/clock_domain_gating_control.sv ***
// Clock domain generation, division and gating with its register file.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "clock_domain_gating_map.svh"
module clock_domain_gating_control (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM register slave.
  input wire clk_pkg::word_t avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire clk_pkg::word_t avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output clk_pkg::word_t avs_readdata_out,
  output logic avs_waitrequest_out,
  // Clock source pins and PLL slip indicators.
  input wire logic main_oscillator_input_in,
  input wire logic main_pll_in,
  input wire logic ext_clock1_in,
  input wire logic lowfreq_internal_osc_clock_in,
  input wire logic highfreq_internal_osc_clock_in,
  input wire logic secondary_pll_in,
  input wire logic ext_clock2_in,
  input wire logic main_pll_slip_in,
  input wire logic secondary_pll_slip_in,
  // PLL configuration and slip reset.
  output clk_pkg::word_t main_pll_config_a_out,
  output clk_pkg::word_t main_pll_config_b_out,
  output clk_pkg::word_t secondary_pll_config_out,
  output logic slip_reset_request_out,
  // Domain clocks.
  output logic cpu_core_clock_out,
  output logic host_bus_clock_out,
  output logic primary_peripheral_clock_out,
  output logic second_peripheral_clock_out,
  output logic async_peripheral_clock1_out,
  output logic async_peripheral_clock2_out,
  output logic realtime_irq_clock_out,
  output logic cpu_core_clock_delayed_out,
  output logic third_peripheral_clock_out,
  output logic async_divided_clock3_out,
  output logic async_source_clock3_out,
  output logic async_peripheral_clock4_out
);
  import clk_pkg::*;

  // ==========================================================
  // Reset release.
  logic [1:0] rst_q;
  logic rstn;

  // Release is synchronous so that every flop leaves reset together.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rstn = rst_q[1];

  // ==========================================================
  // Pin synchronisers and filters.
  logic [9:0] pin, s1, s2, s3, pf, pf_d, rise;
  logic [7:0] src;

  // Bit index equals the clock source number; 2 is reserved.
  assign pin = {secondary_pll_slip_in, main_pll_slip_in, ext_clock2_in,
    secondary_pll_in, highfreq_internal_osc_clock_in,
    lowfreq_internal_osc_clock_in, ext_clock1_in, 1'b0, main_pll_in,
    main_oscillator_input_in};

  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : g_pin
      // A change counts only once stages two and three agree.
      always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          pf[g] <= 1'b0;
          pf_d[g] <= 1'b0;
        end else begin
          s1[g] <= pin[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          pf[g] <= (s2[g] == s3[g]) ? s3[g] : pf[g];
          pf_d[g] <= pf[g];
        end
      end
    end
  endgenerate
  assign rise = pf & ~pf_d;
  assign src = pf[7:0];

  // ==========================================================
  // Registers.
  word_t selftest_clock_divider, async_clock3_divider_control;
  word_t domain_disable_register, main_domain_source_select;
  word_t async_domain_source_select, realtime_clock_source_select;
  word_t periph_divider, main_pll_control_a, main_pll_control_b;
  word_t secondary_pll_control, global_status_register, rdata;
  logic wr_ok, oscillator_fail_flag, osc_valid, slip_rst;
  logic [1:0] slip_flag;

  assign wr_ok = avs_write_in && !avs_waitrequest_out;

  function automatic word_t merge(word_t o, word_t n, logic [3:0] be);
    word_t r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return merge_fix(r);
  endfunction

  function automatic word_t merge_fix(word_t r);
    return r;
  endfunction

  // Software writes take effect at the edge after the wait cycle, while waitrequest is low.
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      selftest_clock_divider <= `RST_ZERO;
      async_clock3_divider_control <= `RST_A3CON;
      domain_disable_register <= `RST_ZERO;
      main_domain_source_select <= `RST_ZERO;
      async_domain_source_select <= `RST_ASRC;
      realtime_clock_source_select <= `RST_RSRC;
      periph_divider <= `RST_ZERO;
      main_pll_control_a <= `RST_ZERO;
      main_pll_control_b <= `RST_ZERO;
      secondary_pll_control <= `RST_ZERO;
    end else if (wr_ok) begin
      unique case (avs_address_in)
        `OFS_STDIV: selftest_clock_divider <= merge(selftest_clock_divider,
          avs_writedata_in, avs_byteenable_in);
        `OFS_A3CON: async_clock3_divider_control <= merge(
          async_clock3_divider_control, avs_writedata_in, avs_byteenable_in);
        `OFS_DDIS: domain_disable_register <= merge(domain_disable_register,
          avs_writedata_in, avs_byteenable_in);
        `OFS_MSRC: main_domain_source_select <= merge(
          main_domain_source_select, avs_writedata_in, avs_byteenable_in);
        `OFS_ASRC: async_domain_source_select <= merge(
          async_domain_source_select, avs_writedata_in, avs_byteenable_in);
        `OFS_RSRC: realtime_clock_source_select <= merge(
          realtime_clock_source_select, avs_writedata_in, avs_byteenable_in);
        `OFS_PDIV: periph_divider <= merge(periph_divider,
          avs_writedata_in, avs_byteenable_in);
        `OFS_PLLA: main_pll_control_a <= merge(main_pll_control_a,
          avs_writedata_in, avs_byteenable_in);
        `OFS_PLLB: main_pll_control_b <= merge(main_pll_control_b,
          avs_writedata_in, avs_byteenable_in);
        `OFS_PLLC: begin
          // The modulation bit is forced off here, whatever is written.
          secondary_pll_control <= merge(secondary_pll_control,
            avs_writedata_in, avs_byteenable_in);
          secondary_pll_control[`FMOD_BIT] <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Status: hardware set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      slip_flag <= 2'h0;
      slip_rst <= 1'b0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (rise[8+k]) begin
          slip_flag[k] <= 1'b1;
        end else if (wr_ok && avs_address_in == `OFS_GSTAT &&
                     avs_writedata_in[`GS_SLIP1+k]) begin
          slip_flag[k] <= 1'b0;
        end
      end
      slip_rst <= (rise[8] && main_pll_control_a[`SLIPRST_BIT]) ||
        (rise[9] && secondary_pll_control[`SLIPRST_BIT]);
    end
  end

  always_comb begin
    global_status_register = `RST_ZERO;
    global_status_register[`GS_FAIL] = oscillator_fail_flag;
    global_status_register[`GS_SLIP1] = slip_flag[0];
    global_status_register[`GS_SLIP2] = slip_flag[1];
    global_status_register[`GS_VALID] = osc_valid;
  end

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    unique case (avs_address_in)
      `OFS_STDIV: rdata = selftest_clock_divider;
      `OFS_A3CON: rdata = async_clock3_divider_control;
      `OFS_DDIS: rdata = domain_disable_register;
      `OFS_MSRC: rdata = main_domain_source_select;
      `OFS_ASRC: rdata = async_domain_source_select;
      `OFS_RSRC: rdata = realtime_clock_source_select;
      `OFS_PDIV: rdata = periph_divider;
      `OFS_GSTAT: rdata = global_status_register;
      `OFS_PLLA: rdata = main_pll_control_a;
      `OFS_PLLB: rdata = main_pll_control_b;
      `OFS_PLLC: rdata = secondary_pll_control;
      default: rdata = `RST_ZERO;
    endcase
  end

  // One wait cycle, then a single cycle of answer.
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= `RST_ZERO;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
        avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rdata;
      end
    end
  end

  // ==========================================================
  // Main oscillator monitor against the high-frequency reference.
  logic [3:0] win;
  logic [6:0] osc_cnt;
  logic win_end, win_bad;

  assign win_end = rise[5] && win == `MON_LAST;
  assign win_bad = !(osc_cnt > `OSC_LO && osc_cnt < `OSC_HI);

  // The count saturates so that a fast oscillator cannot wrap into range.
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      win <= 4'h0;
      osc_cnt <= 7'h00;
      osc_valid <= 1'b0;
      oscillator_fail_flag <= 1'b0;
    end else begin
      if (rise[5]) begin
        win <= win + 4'h1;
      end
      if (win_end) begin
        osc_cnt <= {6'h00, rise[0]};
        osc_valid <= !win_bad;
      end else if (rise[0] && osc_cnt != 7'h7F) begin
        osc_cnt <= osc_cnt + 7'h01;
      end
      if (win_end && win_bad) begin
        oscillator_fail_flag <= 1'b1;
      end else if (wr_ok && avs_address_in == `OFS_GSTAT &&
                   avs_writedata_in[`GS_FAIL]) begin
        oscillator_fail_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Source selection, dividers and gates.
  logic [11:0] lv, en, gen, clk_q;
  logic [4:0] ph, bprev, base;
  logic [1:0] phd;
  logic [3:0] rat [5];
  logic [3:0] cnt [5];
  logic [4:0] n1, n2;
  logic host, p2ok;

  // Oscillator-sourced selections fall back to source 5 after a failure.
  function automatic logic pick(src_code_t c, logic [7:0] s, logic p,
                                logic f);
    logic [2:0] i;
    i = (f && c == 4'h0) ? `SRC_LIMP : c[2:0];
    if (c == `SRC_PERIPH) begin
      return p;
    end
    return c[3] ? 1'b0 : s[i];
  endfunction

  assign host = pick({1'b0, main_domain_source_select[2:0]}, src, 1'b0,
    oscillator_fail_flag);
  assign n1 = {1'b0, periph_divider[3:0]} + 5'h01;
  assign n2 = {1'b0, periph_divider[11:8]} + 5'h01;
  assign p2ok = (n1 % n2) == 5'h00;

  always_comb begin
    rat[0] = selftest_clock_divider[`ST_ACT_BIT] ?
      {1'b0, selftest_clock_divider[2:0]} : 4'h0;
    rat[1] = periph_divider[3:0];
    rat[2] = p2ok ? periph_divider[11:8] : periph_divider[3:0];
    rat[3] = periph_divider[19:16];
    rat[4] = {1'b0, async_clock3_divider_control[2:0]};
    base = {lv[10], host, host, host, host};
  end

  generate
    for (g = 0; g < 5; g++) begin : g_div
      // Ratios load only at the wrap, so no phase is ever shortened.
      always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
          bprev[g] <= 1'b0;
          cnt[g] <= 4'h0;
          ph[g] <= 1'b1;
        end else begin
          bprev[g] <= base[g];
          if (bprev[g] && !base[g]) begin
            if (cnt[g] == 4'h0) begin
              cnt[g] <= rat[g];
              ph[g] <= 1'b1;
            end else begin
              cnt[g] <= cnt[g] - 4'h1;
              ph[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // The delayed CPU copy takes the CPU phase two host cycles later.
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      phd <= 2'h3;
    end else if (bprev[0] && !host) begin
      phd <= {phd[0], ph[0]};
    end
  end

  always_comb begin
    lv[0] = host & ph[0];
    lv[1] = host;
    lv[2] = host & ph[1];
    lv[3] = host & ph[2];
    lv[4] = pick(async_domain_source_select[3:0], src, clk_q[2],
      oscillator_fail_flag);
    lv[5] = pick(async_domain_source_select[11:8], src, clk_q[2],
      oscillator_fail_flag);
    lv[6] = pick(realtime_clock_source_select[3:0], src, clk_q[2],
      oscillator_fail_flag);
    lv[7] = host & phd[1];
    lv[8] = host & ph[3];
    // The async3 source is settled first so its divided copy reads it.
    lv[10] = pick(async_clock3_divider_control[19:16], src, clk_q[2],
      oscillator_fail_flag);
    lv[9] = lv[10] & ph[4];
    lv[11] = pick(async_clock3_divider_control[27:24], src, clk_q[2],
      oscillator_fail_flag);
    en = ~domain_disable_register[11:0];
    en[7] = ~domain_disable_register[0];
    en[9] = ~domain_disable_register[10] &
      ~async_clock3_divider_control[`A3_DIVDIS_BIT];
  end

  generate
    for (g = 0; g < 12; g++) begin : g_gate
      // The enable changes only while the clock is low.
      always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
          gen[g] <= 1'b1;
          clk_q[g] <= 1'b0;
        end else begin
          if (!lv[g]) begin
            gen[g] <= en[g];
          end
          clk_q[g] <= lv[g] & gen[g];
        end
      end
    end
  endgenerate

  assign cpu_core_clock_out = clk_q[0];
  assign host_bus_clock_out = clk_q[1];
  assign primary_peripheral_clock_out = clk_q[2];
  assign second_peripheral_clock_out = clk_q[3];
  assign async_peripheral_clock1_out = clk_q[4];
  assign async_peripheral_clock2_out = clk_q[5];
  assign realtime_irq_clock_out = clk_q[6];
  assign cpu_core_clock_delayed_out = clk_q[7];
  assign third_peripheral_clock_out = clk_q[8];
  assign async_divided_clock3_out = clk_q[9];
  assign async_source_clock3_out = clk_q[10];
  assign async_peripheral_clock4_out = clk_q[11];
  assign main_pll_config_a_out = main_pll_control_a;
  assign main_pll_config_b_out = main_pll_control_b;
  assign secondary_pll_config_out = secondary_pll_control;
  assign slip_reset_request_out = slip_rst;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn);

  a_host_gate_stop: assert property (
    domain_disable_register[1] && !lv[1] ##1 domain_disable_register[1]
    |=> !clk_q[1]) else $error("host clock runs while disabled");
  a_bus_one_wait: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer late");
  a_bus_answer_once: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("bus answer longer than a cycle");
  a_fail_flag_set: assert property (
    $rose(oscillator_fail_flag) |-> $past(win_end) && !$past(osc_valid) ||
    $past(win_end && win_bad)) else $error("fail flag without cause");
  a_cpu_div_load: assert property (
    bprev[0] && !host && cnt[0] == 4'h0
    |=> ph[0] && cnt[0] == $past(rat[0])) else $error("cpu ratio load");
  a_cpu_copy_lag: assert property (
    bprev[0] && !host |=> phd[0] == $past(ph[0]))
    else $error("delayed cpu phase wrong");
  a_p2_multiple: assert property (
    ((5'h01 + {1'b0, rat[1]}) % (5'h01 + {1'b0, rat[2]})) == 5'h00)
    else $error("second peripheral not a multiple");
  a_slip_reset: assert property (
    rise[8] && main_pll_control_a[`SLIPRST_BIT] |=> slip_reset_request_out)
    else $error("slip reset missing");
  a_secondary_pll_no_fm: assert property (
    !secondary_pll_config_out[`FMOD_BIT])
    else $error("secondary pll modulation set");
endmodule

// *** dv/clock_source_model.sv ***
// Behavioural model of the clock sources and PLL slip pins.
`timescale 1ns/1ps
module clock_source_model (
  // Source clocks.
  output logic osc_out,
  output logic mpll_out,
  output logic ext1_out,
  output logic lf_out,
  output logic hf_out,
  output logic spll_out,
  output logic ext2_out,
  // Slip indicators.
  output logic slip1_out,
  output logic slip2_out
);
  logic osc_run;
  // ==========================================================
  // Free-running sources, all slower than a quarter of the system clock,
  // so that the input synchronisers never miss a phase.
  initial begin
    {osc_out, mpll_out, ext1_out, lf_out, hf_out} = 5'h00;
    {spll_out, ext2_out, slip1_out, slip2_out} = 4'h0;
    osc_run = 1'b1;
  end
  // Non-blocking toggles, since some of them land on a clock edge.
  always #20 osc_out <= osc_run & ~osc_out;
  always #15 mpll_out <= ~mpll_out;
  always #25 ext1_out <= ~ext1_out;
  always #200 lf_out <= ~lf_out;
  always #24 hf_out <= ~hf_out;
  always #17 spll_out <= ~spll_out;
  always #30 ext2_out <= ~ext2_out;
  // A failed crystal goes silent; the monitor must notice the silence.
  task stop_osc();
    osc_run = 1'b0;
  endtask
  // Slip pulses are wide so that the synchronisers always catch them.
  task slip(input int which);
    if (which == 0) slip1_out <= 1'b1;
    else slip2_out <= 1'b1;
    #40;
    {slip1_out, slip2_out} <= 2'h0;
  endtask
endmodule

// *** dv/test_clock_domain_gating_control.sv ***
// Self-checking testbench for the clock domain gating block.
`timescale 1ns/1ps
`include "clock_domain_gating_map.svh"
module test_clock_domain_gating_control;
  import clk_pkg::*;
  logic clk_in, rstn_in, rd_in, wr_in, waitreq, slip_rst;
  word_t addr, wdata, rdata, cfg_a, cfg_b, cfg_c, got, r;
  wire [11:0] ck;
  wire osc, mpll, ext1, lf, hf, spll, ext2, slip1, slip2;
  int bad_count, samples_checked, cyc, slips, n1, n2, n3;
  int cnt[12];
  word_t ra[6] = '{`OFS_A3CON, `OFS_ASRC, `OFS_RSRC, `OFS_DDIS,
    `OFS_STDIV, 32'hFFFFE1F0};
  word_t re[6] = '{`RST_A3CON, `RST_ASRC, `RST_RSRC, 0, 0, 0};
  // ==========================================================
  // Design and source model.
  clock_domain_gating_control uut (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(addr), .avs_read_in(rd_in), .avs_write_in(wr_in),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .main_oscillator_input_in(osc), .main_pll_in(mpll),
    .ext_clock1_in(ext1), .lowfreq_internal_osc_clock_in(lf),
    .highfreq_internal_osc_clock_in(hf), .secondary_pll_in(spll),
    .ext_clock2_in(ext2), .main_pll_slip_in(slip1),
    .secondary_pll_slip_in(slip2), .main_pll_config_a_out(cfg_a),
    .main_pll_config_b_out(cfg_b), .secondary_pll_config_out(cfg_c),
    .slip_reset_request_out(slip_rst), .cpu_core_clock_out(ck[0]),
    .host_bus_clock_out(ck[1]), .primary_peripheral_clock_out(ck[2]),
    .second_peripheral_clock_out(ck[3]),
    .async_peripheral_clock1_out(ck[4]),
    .async_peripheral_clock2_out(ck[5]), .realtime_irq_clock_out(ck[6]),
    .cpu_core_clock_delayed_out(ck[7]),
    .third_peripheral_clock_out(ck[8]), .async_divided_clock3_out(ck[9]),
    .async_source_clock3_out(ck[10]),
    .async_peripheral_clock4_out(ck[11]));
  clock_source_model src (.osc_out(osc), .mpll_out(mpll),
    .ext1_out(ext1), .lf_out(lf), .hf_out(hf), .spll_out(spll),
    .ext2_out(ext2), .slip1_out(slip1), .slip2_out(slip2));
  // ==========================================================
  // Clock, cycle limit and slip pulse counter.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (slip_rst === 1'b1) slips++;
    if (cyc == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  // One bus cycle; the request is held until waitrequest is seen low.
  task xfer(input logic w, input word_t a, input word_t d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_in <= w;
    rd_in <= ~w;
    @(posedge clk_in);
    while (waitreq !== 1'b0) @(posedge clk_in);
    got = rdata;
    {wr_in, rd_in} <= 2'h0;
  endtask
  // Counts rising edges of every domain; settles first so that a
  // ratio change can wait for its divided clock boundary.
  task count(input int n);
    logic [11:0] prev;
    cnt = '{default: 0};
    repeat (200) @(posedge clk_in);
    prev = ck;
    repeat (n) begin
      @(posedge clk_in);
      for (int i = 0; i < 12; i++) cnt[i] += int'(ck[i] & ~prev[i]);
      prev = ck;
    end
  endtask
  // Compares within a tolerance, since sampled edges can jitter by one.
  task chk(input string n, input word_t g, input word_t e, input int t);
    samples_checked++;
    if (g !== e && !(t > 0 && !$isunknown(g) && g + t >= e &&
        g <= e + t)) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task stop_test();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence. The real-time clock stays on its primary source.
  initial begin
    {rstn_in, rd_in, wr_in} = 3'h0;
    addr = 32'h00000000;
    wdata = 32'h00000000;
    void'($urandom(53793));
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 32'h0);
      chk("reset value", got, re[i], 0);
    end
    $display("Test reset values done");
    for (int i = 0; i < 12; i++) if (i != 7 && i != 9) begin
      xfer(1'b1, `OFS_DDIS, 32'h1 << i);
      count(400);
      chk("gated domain", cnt[i], 0, 0);
      if (i == 0) chk("delayed gated", cnt[7], 0, 0);
      if (i == 10) chk("divided gated", cnt[9], 0, 0);
    end
    xfer(1'b1, `OFS_DDIS, 32'h0);
    count(400);
    for (int i = 0; i < 12; i++) begin
      chk("running", cnt[i], i == 9 ? 20 : 40, 2);
    end
    $display("Test gating done");
    n2 = $urandom_range(1, 16);
    n1 = n2 * $urandom_range(1, 16 / n2);
    n3 = $urandom_range(1, 16);
    xfer(1'b1, `OFS_PDIV, (n1 - 1) | (n2 - 1) << 8 | (n3 - 1) << 16);
    count(2000);
    chk("primary", cnt[2], 200 / n1, 1);
    chk("second", cnt[3], 200 / n2, 1);
    chk("third", cnt[8], 200 / n3, 1);
    chk("async1", cnt[4], 200 / n1, 1);
    // Ratios 5 and 2 are no multiple pair, so the second follows primary.
    xfer(1'b1, `OFS_PDIV, 32'h00000104);
    count(2000);
    chk("second fallback", cnt[3], 40, 1);
    xfer(1'b1, `OFS_PDIV, 32'h00000000);
    n1 = $urandom_range(1, 8);
    xfer(1'b1, `OFS_STDIV, 32'h100 | (n1 - 1));
    count(2000);
    chk("selftest cpu", cnt[0], 200 / n1, 1);
    chk("selftest delayed", cnt[7], 200 / n1, 1);
    xfer(1'b1, `OFS_STDIV, 32'h0);
    n1 = $urandom_range(1, 8);
    xfer(1'b1, `OFS_A3CON, `RST_A3CON & 32'hFFFFFFF8 | (n1 - 1));
    count(2000);
    chk("async3 ratio", cnt[9], 200 / n1, 1);
    xfer(1'b1, `OFS_A3CON, `RST_A3CON | 32'h10);
    count(400);
    chk("async3 own gate", cnt[9], 0, 0);
    chk("async3 source", cnt[10] > 0, 1, 0);
    $display("Test dividers done");
    xfer(1'b1, `OFS_ASRC, 32'h00000603);
    xfer(1'b1, `OFS_MSRC, 32'h4);
    count(2000);
    chk("lowfreq source", cnt[1], 20, 1);
    chk("async1 source", cnt[4], 160, 2);
    chk("async2 source", cnt[5], 235, 2);
    xfer(1'b1, `OFS_MSRC, 32'h5);
    count(2000);
    chk("highfreq source", cnt[1], 166, 2);
    xfer(1'b1, `OFS_MSRC, 32'h0);
    $display("Test source select done");
    r = $urandom();
    xfer(1'b1, `OFS_PLLC, 32'hFFFFFFFF);
    xfer(1'b1, `OFS_PLLB, r | 32'h80000000);
    xfer(1'b1, `OFS_PLLA, r | 32'h1);
    xfer(1'b0, `OFS_PLLC, 32'h0);
    chk("secondary pll", got, 32'h7FFFFFFF, 0);
    chk("secondary cfg", cfg_c, 32'h7FFFFFFF, 0);
    chk("main cfg b", cfg_b, r | 32'h80000000, 0);
    chk("main cfg a", cfg_a, r | 32'h1, 0);
    slips = 0;
    src.slip(0);
    src.slip(1);
    repeat (20) @(posedge clk_in);
    chk("slip resets", slips, 2, 0);
    xfer(1'b0, `OFS_GSTAT, 32'h0);
    chk("slip flags", got & 32'h300, 32'h300, 0);
    xfer(1'b1, `OFS_GSTAT, 32'h00000300);
    xfer(1'b0, `OFS_GSTAT, 32'h0);
    chk("slip clear", got & 32'h300, 32'h0, 0);
    $display("Test pll done");
    chk("osc valid", got & 32'h10001, 32'h10000, 0);
    src.stop_osc();
    repeat (600) @(posedge clk_in);
    xfer(1'b0, `OFS_GSTAT, 32'h0);
    chk("oscillator_fail_flag", got & 32'h10001, 32'h1, 0);
    count(2000);
    chk("limp host", cnt[1], 166, 2);
    $display("Test oscillator fail done");
    stop_test();
  end
endmodule
